// File: design/sms_supervisor.sv
// Supervisor for a switch-monitoring device: power-up and reset sequence,
// run control with configuration lock, supply fault entry and recovery,
// interrupt status and serial status flags, APB register access.
// Assumes pclk at 25 MHz; serial core, polling logic and comparators sit
// outside and exchange single-cycle pulses and levels with this block.
//
// Functional notes
// - Power-on release loads defaults, flags power-up.
// - Failed factory self-check sets trim error.
// - Run bit set starts wetting and monitoring.
// - Configuration locked while running, listed exceptions.
// - Run bit clear stops monitoring, unlocks config.
// - Hardware reset high: stop, clear registers.
// - Reset release: defaults, reinit, flag power-up.
// - Software reset bit reinitialises, flags power-up.
// - Supply fault turns sources off, halts monitoring.
// - Low supply entry: interrupt, event, present bit.
// - High supply entry: interrupt, event, present bit.
// - Pending supply fault raises serial other-flag.
// - Chip select rise clears status if read.
// - Faults keep serial and registers intact.
// - Persisting fault raises no further interrupt.
// - Low supply recovery: interrupt, event, present clear.
// - High supply recovery: interrupt, event, present clear.
// - Recovery resumes with settings, polling restarts.
// - First poll after recovery flags switch change.
// - Power-on fall resets and clears everything.
// - Reset with pending interrupt within 1 ms.
//
// The address map and the APB register port were chosen for this implementation.

`timescale 1ns/1ns

module sms_supervisor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and comparator levels from outside the clock domain
  input  wire logic        cs_n,
  input  wire logic        hw_reset,
  input  wire logic        por_ok,
  input  wire logic        low_supply,
  input  wire logic        high_supply,
  // Same-domain inputs from factory load and polling logic
  input  wire logic        trim_ok,
  input  wire logic        poll_done,
  input  wire logic        switch_change_in,
  // Outputs to pins and neighbouring logic
  output logic             int_n,
  output logic             int_n_oe,
  output logic             pup_serial_flag,
  output logic             other_irq_serial_flag,
  output logic             serial_en,
  output logic             wetting_en,
  output logic             monitor_en,
  output logic             poll_restart,
  output logic             crc_start,
  output logic      [31:0] cfg_word,
  output logic      [31:0] clean_cfg_reg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sms_pkg::sms_state_t          st;         // Supervisor state
    logic [sms_pkg::INIT_CNT_W-1:0] cnt;      // Init progress
    logic                         run;        // Monitoring run bit
    logic [31:0]                  cfg;        // Lockable configuration
    logic [31:0]                  clean;      // Clean-current config
    sms_pkg::sms_irq_t            irq;        // Interrupt status
    logic                         low_pres;   // Low supply present
    logic                         high_pres;  // High supply present
    logic                         irq_read;   // Status read this frame
    logic                         cs_q;       // Last chip select level
    logic                         low_q;      // Last low supply level
    logic                         high_q;     // Last high supply level
    logic                         base_wait;  // Waiting baseline poll
    logic                         poll_rst;   // Polling restart pulse
    logic                         crc_go;     // Checksum start pulse
    logic                         wet;        // Wetting current on
    logic                         mon;        // Monitoring on
    logic                         ser;        // Serial link enabled
    logic                         intn;       // Interrupt pin level
    logic                         pup;        // Serial power-up flag
    logic                         oi;         // Serial other-irq flag
    logic                         rdy;        // APB ready
    logic                         err;        // APB error
    logic [31:0]                  rdata;      // APB read data
  } sms_regs_t;

  sms_regs_t          r;      // Registered state
  sms_regs_t          nxt;    // Next state
  sms_pkg::sms_pins_t pins;   // Synchronised pin levels
  sms_pkg::sms_pins_t raw;    // Raw pin levels

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Group raw levels for the synchroniser
  assign raw = '{cs_n: cs_n, hw_reset: hw_reset, por_ok: por_ok,
                 low_supply: low_supply, high_supply: high_supply};

  // All pin levels pass three stages with agreement
  sms_sync #(
    .W   (sms_pkg::PINS_W),
    .RST (sms_pkg::PINS_RST)
  ) u_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .clk_en (clk_en),
    .din    (raw),
    .dout   (pins)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic              hard_rst;  // Pin reset or power-on fall
  logic              fault;     // Any supply fault present
  logic              cs_rise;   // End of a serial frame
  logic              acc;       // APB access phase
  logic              done;      // APB transfer completes this edge
  logic              wr;        // Write completes this edge
  logic              rd;        // Read completes this edge
  logic [sms_pkg::ADDR_W-1:0] addr;  // Decoded address
  logic              mapped;    // Address hits a register
  logic              operating; // Past initialisation
  sms_pkg::sms_irq_t ev;        // Events raised this cycle

  always_comb begin
    nxt       = r;
    ev        = '0;
    nxt.poll_rst = 1'b0;
    nxt.crc_go   = 1'b0;
    // Reset sources, pin and supply
    hard_rst  = pins.hw_reset | ~pins.por_ok;
    fault     = pins.low_supply | pins.high_supply;
    operating = (r.st == sms_pkg::SMS_ST_READY) ||
                (r.st == sms_pkg::SMS_ST_RUN) ||
                (r.st == sms_pkg::SMS_ST_FAULT);

    // Chip select rising edge marks the end of a frame
    cs_rise  = pins.cs_n & ~r.cs_q;
    nxt.cs_q = pins.cs_n;
    // APB: ready one cycle into the access phase
    acc     = psel & penable;
    done    = acc & r.rdy;
    wr      = done & pwrite;
    rd      = done & ~pwrite;
    addr    = paddr[sms_pkg::ADDR_W-1:0];
    mapped  = (paddr[31:sms_pkg::ADDR_W] == '0) &&
              ((addr == sms_pkg::ADDR_CTRL) ||
               (addr == sms_pkg::ADDR_CFG) ||
               (addr == sms_pkg::ADDR_CLEAN) ||
               (addr == sms_pkg::ADDR_INT_STAT) ||
               (addr == sms_pkg::ADDR_MISC_STAT));
    nxt.rdy = acc & ~r.rdy;
    nxt.err = acc & ~r.rdy & ~mapped;
    // Read data captured with ready, registers stay readable
    // Unmapped reads keep the zero default
    nxt.rdata = sms_pkg::DATA_ZERO;
    if (acc && !r.rdy && !pwrite && mapped) begin
      case (addr)
        sms_pkg::ADDR_CTRL:     nxt.rdata[sms_pkg::CTRL_RUN_BIT] = r.run;
        sms_pkg::ADDR_CFG:      nxt.rdata = r.cfg;
        sms_pkg::ADDR_CLEAN:    nxt.rdata = r.clean;
        sms_pkg::ADDR_INT_STAT: nxt.rdata = 32'(r.irq);
        sms_pkg::ADDR_MISC_STAT: begin
          nxt.rdata[sms_pkg::MISC_LOW_BIT]  = r.low_pres;
          nxt.rdata[sms_pkg::MISC_HIGH_BIT] = r.high_pres;
          nxt.rdata[sms_pkg::MISC_RUN_BIT]  = r.mon;
        end
        default:                nxt.rdata = sms_pkg::DATA_ZERO;
      endcase
    end
    // Status read marks the frame for clearing
    if (rd && mapped && addr == sms_pkg::ADDR_INT_STAT) begin
      nxt.irq_read = 1'b1;
    end
    // Register writes
    if (wr && mapped) begin
      case (addr)
        sms_pkg::ADDR_CTRL: begin
          // Run bit always writable
          nxt.run    = pwdata[sms_pkg::CTRL_RUN_BIT];
          nxt.crc_go = pwdata[sms_pkg::CTRL_CRC_BIT];
        end
        sms_pkg::ADDR_CFG: begin
          // Locked while running
          if (!r.run) begin
            nxt.cfg = pwdata;
          end
        end
        sms_pkg::ADDR_CLEAN: begin
          // Clean-current config writable at all times
          nxt.clean = pwdata;
        end
        default: ;  // Status words are read-only
      endcase
    end
    // Supply edges, one event per entry and per recovery
    nxt.low_q  = pins.low_supply;
    nxt.high_q = pins.high_supply;
    if (operating) begin
      if (pins.low_supply != r.low_q) begin
        ev.low_supply_event_bit = 1'b1;
        nxt.low_pres            = pins.low_supply;
      end
      if (pins.high_supply != r.high_q) begin
        ev.high_supply_event_bit = 1'b1;
        nxt.high_pres            = pins.high_supply;
      end
      // First poll after recovery becomes the baseline
      if (poll_done && r.base_wait) begin
        ev.switch_change_event = 1'b1;
        nxt.base_wait          = 1'b0;
      end else if (switch_change_in && !r.base_wait) begin
        ev.switch_change_event = 1'b1;
      end
    end
    // Status clear on frame end if read; new events win
    if (cs_rise && r.irq_read) begin
      nxt.irq      = ev;
      nxt.irq_read = 1'b0;
    end else begin
      nxt.irq = r.irq | ev;
    end
    // Supervisor sequence
    case (r.st)
      sms_pkg::SMS_ST_RESET: begin
        if (!hard_rst) begin
          nxt.st  = sms_pkg::SMS_ST_INIT;
          nxt.cnt = '0;
        end
      end
      sms_pkg::SMS_ST_INIT: begin
        // Defaults load while factory settings are programmed
        nxt.cfg   = sms_pkg::CFG_RST;
        nxt.clean = sms_pkg::CLEAN_RST;
        nxt.run   = 1'b0;
        nxt.cnt   = r.cnt + 1'b1;
        if (r.cnt == sms_pkg::INIT_CYCLES) begin
          nxt.st = sms_pkg::SMS_ST_CHECK;
        end
      end
      sms_pkg::SMS_ST_CHECK: begin
        // Power-up flag, with trim error on a failed
        nxt.irq.power_up         = 1'b1;
        nxt.irq.trim_check_error = ~trim_ok;
        nxt.low_q     = 1'b0;
        nxt.high_q    = 1'b0;
        nxt.st        = sms_pkg::SMS_ST_READY;
      end
      sms_pkg::SMS_ST_READY: begin
        if (nxt.run && !fault) begin
          nxt.st = sms_pkg::SMS_ST_RUN;
        end
      end
      sms_pkg::SMS_ST_RUN: begin
        if (fault) begin
          nxt.st = sms_pkg::SMS_ST_FAULT;
        end else if (!nxt.run) begin
          nxt.st = sms_pkg::SMS_ST_READY;
        end
      end
      sms_pkg::SMS_ST_FAULT: begin
        // Resume with current settings, restart polling
        if (!fault) begin
          if (nxt.run) begin
            nxt.st        = sms_pkg::SMS_ST_RUN;
            nxt.poll_rst  = 1'b1;
            nxt.base_wait = 1'b1;
          end else begin
            nxt.st = sms_pkg::SMS_ST_READY;
          end
        end else if (!nxt.run) begin
          nxt.st = sms_pkg::SMS_ST_READY;
        end
      end
      default: nxt.st = sms_pkg::SMS_ST_RESET;
    endcase
    // Software reset reinitialises everything
    if (wr && mapped && addr == sms_pkg::ADDR_CTRL &&
        pwdata[sms_pkg::CTRL_SWRST_BIT]) begin
      nxt.st        = sms_pkg::SMS_ST_INIT;
      nxt.cnt       = '0;
      nxt.irq       = '0;
      nxt.irq_read  = 1'b0;
      nxt.low_pres  = 1'b0;
      nxt.high_pres = 1'b0;
      nxt.base_wait = 1'b0;
      nxt.crc_go    = 1'b0;
    end
    // Pin reset or power-on fall clears all, no wait
    if (hard_rst) begin
      nxt.st        = sms_pkg::SMS_ST_RESET;
      nxt.cnt       = '0;
      nxt.run       = 1'b0;
      nxt.cfg       = '0;
      nxt.clean     = '0;
      nxt.irq       = '0;
      nxt.low_pres  = 1'b0;
      nxt.high_pres = 1'b0;
      nxt.irq_read  = 1'b0;
      nxt.base_wait = 1'b0;
      nxt.crc_go    = 1'b0;
      nxt.poll_rst  = 1'b0;
    end
    // Pin and flag levels follow the next state
    nxt.wet  = (nxt.st == sms_pkg::SMS_ST_RUN);
    nxt.mon  = (nxt.st == sms_pkg::SMS_ST_RUN);
    nxt.ser  = (nxt.st != sms_pkg::SMS_ST_RESET);
    nxt.intn = ~(|nxt.irq);
    nxt.pup  = nxt.irq.power_up;
    nxt.oi   = nxt.irq.low_supply_event_bit |
               nxt.irq.high_supply_event_bit;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // All state frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.st   <= sms_pkg::SMS_ST_RESET;
      r.cs_q <= 1'b1;
      r.intn <= 1'b1;
    end else if (clk_en) begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from the state register except int_n, tied low, and int_n_oe, the inverse of r.intn
  // ----------------------------------------------------------------
  assign prdata                = r.rdata;
  assign pready                = r.rdy;
  assign pslverr               = r.err;
  assign int_n                 = 1'b0;     // Open drain pulls low only
  assign int_n_oe              = ~r.intn;  // Drive while pending
  assign pup_serial_flag       = r.pup;
  assign other_irq_serial_flag = r.oi;
  assign serial_en             = r.ser;
  assign wetting_en            = r.wet;
  assign monitor_en            = r.mon;
  assign poll_restart          = r.poll_rst;
  assign crc_start             = r.crc_go;
  assign cfg_word              = r.cfg;
  assign clean_cfg_reg         = r.clean;

endmodule

// File: design/sms_pkg.sv
// Shared constants and carrier types for the supply supervisor block.
// Assumes a 25 MHz APB clock and comparator levels from the analog side.

package sms_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00; // Run, checksum, reset
  localparam logic [7:0]  ADDR_CFG       = 8'h04; // Locked while running
  localparam logic [7:0]  ADDR_CLEAN     = 8'h08; // Clean-current config
  localparam logic [7:0]  ADDR_INT_STAT  = 8'h0C; // Interrupt status
  localparam logic [7:0]  ADDR_MISC_STAT = 8'h10; // Supply present bits
  localparam int          ADDR_W         = 8;     // Decoded address bits

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;  // Monitoring run bit
  localparam int CTRL_CRC_BIT   = 1;  // Checksum trigger, self-clearing
  localparam int CTRL_SWRST_BIT = 2;  // Software reset, self-clearing
  localparam int MISC_LOW_BIT   = 0;  // Low supply present
  localparam int MISC_HIGH_BIT  = 1;  // High supply present
  localparam int MISC_RUN_BIT   = 2;  // Monitoring active

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST     = 32'h0000_0000; // Config default
  localparam logic [31:0] CLEAN_RST   = 32'h0000_0000; // Clean default
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000; // Unmapped read
  localparam int          INIT_CNT_W  = 4;             // Init count width
  localparam logic [3:0]  INIT_CYCLES = 4'hF;          // Factory load time

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Interrupt status word, bit 0 at the bottom
  typedef struct packed {
    logic switch_change_event;    // Bit 4
    logic high_supply_event_bit;  // Bit 3
    logic low_supply_event_bit;   // Bit 2
    logic trim_check_error;       // Bit 1
    logic power_up;               // Bit 0
  } sms_irq_t;

  // Pin and comparator levels that cross into the pclk domain
  typedef struct packed {
    logic cs_n;         // Serial chip select, active low
    logic hw_reset;     // Hardware reset pin, active high
    logic por_ok;       // Supply above power-on level
    logic low_supply;   // Below low_supply_fall_level, hysteresis applied
    logic high_supply;  // Above high_supply_rise_level, hysteresis applied
  } sms_pins_t;

  localparam int        PINS_W   = $bits(sms_pins_t);
  localparam sms_pins_t PINS_RST = '{cs_n: 1'b1, default: 1'b0};

  // Supervisor states
  typedef enum logic [2:0] {
    SMS_ST_RESET,  // Held in reset, registers cleared
    SMS_ST_INIT,   // Loading defaults and factory settings
    SMS_ST_CHECK,  // Factory settings self-check
    SMS_ST_READY,  // Configurable, monitoring stopped
    SMS_ST_RUN,    // Wetting current and monitoring on
    SMS_ST_FAULT   // Supply fault, sources off
  } sms_state_t;

endpackage

// File: design/sms_sync.sv
// Three-stage synchroniser with agreement filter for pin levels.
// Assumes inputs are asynchronous to clk; output changes only when the
// second and third stages agree.

`timescale 1ns/1ns

module sms_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read only by s2
    logic [W-1:0] s2;   // Second stage
    logic [W-1:0] s3;   // Third stage
    logic [W-1:0] out;  // Filtered level
  } sms_sync_t;

  sms_sync_t r;    // Registered state
  sms_sync_t nxt;  // Next state

  // Shift and accept bits where the last two stages agree
  always_comb begin
    nxt    = r;
    nxt.s1 = din;
    nxt.s2 = r.s1;
    nxt.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        nxt.out[i] = r.s3[i];
      end
    end
  end

  // State register, frozen while clk_en is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= {RST, RST, RST, RST};
    end else if (clk_en) begin
      r <= nxt;
    end
  end

  assign dout = r.out;

endmodule

// File: testbench/sms_supervisor_assertions.sv
// Checker on the supervisor's ports.
// Assumes a bind from the bench top to sms_supervisor.
`timescale 1ns/1ns
module sms_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hw_reset,
  input wire logic por_ok,
  input wire logic low_supply,
  input wire logic int_n,
  input wire logic int_n_oe,
  input wire logic pup_serial_flag,
  input wire logic other_irq_serial_flag,
  input wire logic serial_en,
  input wire logic wetting_en,
  input wire logic monitor_en,
  input wire logic crc_start
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RUN_PAIR: assert property (wetting_en == monitor_en)
    else $error("wetting and monitoring disagree");
  AST_HW_RESET: assert property (hw_reset [*7] |-> !serial_en)
    else $error("serial active in reset");
  AST_POR_FALL: assert property (!por_ok [*7] |-> !int_n_oe)
    else $error("interrupt held through power loss");
  AST_LOW_OFF: assert property (low_supply [*7] |-> !wetting_en)
    else $error("sources on in low supply");
  AST_PUP_INT: assert property (pup_serial_flag |-> int_n_oe)
    else $error("power-up flag without interrupt");
  AST_OI_INT: assert property (other_irq_serial_flag |-> int_n_oe)
    else $error("other flag without interrupt");
  AST_PIN_LOW: assert property (int_n_oe |-> int_n == 1'h0)
    else $error("open-drain pin value not low");
  AST_RESET_QUIET: assert property (!serial_en |-> !int_n_oe && !pup_serial_flag)
    else $error("interrupt or power-up flag while in reset");
  AST_CRC_PULSE: assert property (crc_start |=> !crc_start)
    else $error("checksum trigger longer than a cycle");
  cover property (pready && pslverr);
  cover property (other_irq_serial_flag);
  cover property (wetting_en);
endmodule

// File: testbench/sms_host.sv
// Controller model: chip-select frames and the hardware reset pin.
// Assumes the bench toggles go per frame and holds rq long enough.
`timescale 1ns/1ns
module sms_host (
  input  wire logic go,
  input  wire logic rq,
  output logic      cs_n,
  output logic      hw_reset
);
  initial cs_n = 1'h1;
  // Frame of 320 ns low, starting 7 ns after each change of go
  always @(go) begin
    #7 cs_n = 1'h0;
    #320 cs_n = 1'h1;
  end
  // Low in normal use, held over 2 us per request
  assign hw_reset = rq;
endmodule

// File: testbench/switch_monitor_supervisor_test.sv
// Self-checking bench for the supervisor block.
// Assumes sms_pkg, sms_supervisor, sms_host and sms_chk are compiled.
`timescale 1ns/1ns
module switch_monitor_supervisor_test;
  logic pclk, presetn, psel, penable, pwrite, por, low, high, trim, pd;
  logic go, rq, pready, pslverr, int_n, oe, pup, oi, sen, wet, mon, er;
  logic prs, crc, csn, hwr;
  logic [31:0] paddr, pwdata, prdata, rd, cfg, cln;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  sms_supervisor dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(csn), .hw_reset(hwr), .por_ok(por), .low_supply(low),
    .high_supply(high), .trim_ok(trim), .poll_done(pd),
    .switch_change_in(1'h0), .int_n(int_n), .int_n_oe(oe),
    .pup_serial_flag(pup), .other_irq_serial_flag(oi), .serial_en(sen),
    .wetting_en(wet), .monitor_en(mon), .poll_restart(prs),
    .crc_start(crc), .cfg_word(cfg), .clean_cfg_reg(cln));
  sms_host host (.go(go), .rq(rq), .cs_n(csn), .hw_reset(hwr));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  // APB transfer; holds the request until pready is sampled high
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Ends when oe is sampled high, or at the bench timeout
  task automatic wirq;
    while (oe !== 1'h1) @(posedge pclk);
  endtask
  task automatic frame;
    go <= ~go;
    repeat (20) @(posedge pclk);
  endtask
  task automatic t_pup;
    wirq;
    chk("pup", {oe, pup}, 2'h3);
    chk("pin", int_n, 1'h0);
    frame;
    chk("unread", oe, 1'h1);
    apb(0, sms_pkg::ADDR_INT_STAT, 0);
    chk("int", rd, 32'h1);
    frame;
    chk("clear", {oe, pup}, 2'h0);
    $display("t_pup done");
  endtask
  task automatic t_trim;
    trim <= 0;
    apb(1, sms_pkg::ADDR_CTRL, 32'h4);
    wirq;
    apb(0, sms_pkg::ADDR_INT_STAT, 0);
    chk("trim", rd, 32'h3);
    frame;
    trim <= 1;
    apb(1, sms_pkg::ADDR_CTRL, 32'h4);
    wirq;
    apb(0, sms_pkg::ADDR_INT_STAT, 0);
    chk("swrst", rd, 32'h1);
    frame;
    $display("t_trim done");
  endtask
  task automatic t_lock;
    apb(1, sms_pkg::ADDR_CFG, 32'hA5);
    apb(1, sms_pkg::ADDR_CTRL, 32'h1);
    chk("run", {wet, mon}, 2'h3);
    apb(1, sms_pkg::ADDR_CFG, 32'h5A);
    apb(1, sms_pkg::ADDR_CLEAN, 32'h3C);
    chk("lock cfg", cfg, 32'hA5);
    chk("lock clean", cln, 32'h3C);
    apb(1, sms_pkg::ADDR_CTRL, 32'h3);
    chk("crc", {crc, wet}, 2'h3);
    apb(1, sms_pkg::ADDR_CTRL, 32'h0);
    chk("stop", wet, 1'h0);
    apb(1, sms_pkg::ADDR_CFG, 32'h5A);
    apb(0, sms_pkg::ADDR_CFG, 0);
    chk("unlock", rd, 32'h5A);
    apb(0, 32'h100, 0);
    chk("unmapped err", er, 1'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1, sms_pkg::ADDR_CTRL, 32'h1);
    $display("t_lock done");
  endtask
  task automatic t_sup(int h);
    if (h) high <= 1;
    else low <= 1;
    wirq;
    chk("off", {wet, oi}, 2'h1);
    apb(0, sms_pkg::ADDR_MISC_STAT, 0);
    chk("present", rd, 32'h1 << h);
    apb(0, sms_pkg::ADDR_CFG, 0);
    chk("kept", rd, 32'h5A);
    apb(0, sms_pkg::ADDR_INT_STAT, 0);
    chk("event", rd, 32'h4 << h);
    frame;
    repeat (10) @(posedge pclk);
    chk("quiet", oe, 1'h0);
    low <= 0;
    high <= 0;
    wirq;
    chk("resume", {wet, prs}, 2'h3);
    apb(0, sms_pkg::ADDR_MISC_STAT, 0);
    chk("gone", rd, 32'h4);
    pd <= 1;
    @(posedge pclk);
    pd <= 0;
    apb(0, sms_pkg::ADDR_INT_STAT, 0);
    chk("ssc", rd, 32'h10 | (32'h4 << h));
    frame;
    $display("t_sup done");
  endtask
  task automatic t_rst(int p);
    if (p) por <= 0;
    else rq <= 1;
    repeat (60) @(posedge pclk);
    chk("held", {sen, wet}, 2'h0);
    chk("held cfg", cfg, 32'h0);
    por <= 1;
    rq <= 0;
    wirq;
    chk("pup", pup, 1'h1);
    apb(0, sms_pkg::ADDR_CFG, 0);
    chk("dflt", rd, sms_pkg::CFG_RST);
    frame;
    $display("t_rst done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, low, high, pd, go, rq} = 0;
    {por, trim} = 2'h3;
    {paddr, pwdata} = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_pup;
    t_trim;
    t_lock;
    t_sup(0);
    t_sup(1);
    t_rst(0);
    t_rst(1);
    end_of_test;
  end
endmodule
bind sms_supervisor sms_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .hw_reset(hw_reset), .por_ok(por_ok), .low_supply(low_supply),
  .int_n(int_n), .int_n_oe(int_n_oe), .pup_serial_flag(pup_serial_flag),
  .other_irq_serial_flag(other_irq_serial_flag), .serial_en(serial_en),
  .wetting_en(wetting_en), .monitor_en(monitor_en), .crc_start(crc_start));
